// *** core/tpl_pkg.sv ***
// shared constants for the three-port latch memory and its controller
package tpl_pkg;
  // memory geometry
  localparam int ADDR_W = 3;
  localparam int WORDS = 8;
  localparam int LANES = 3;
  // reset and idle levels
  localparam logic [LANES-1:0] WORD_RESET = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_STEP = 3'h1;
  localparam logic CLK_IDLE = 1'h1;
  localparam logic CLK_WRITE = 1'h0;
  localparam logic SLAVE_GATED = 1'h1;
  localparam logic SLAVE_OPEN = 1'h0;
  typedef logic [LANES-1:0] word_t;
  typedef logic [ADDR_W-1:0] addr_t;
endpackage

// *** core/tpl_if.sv ***
// link between the latch memory and its external controller
`timescale 1ns/1ns
interface tpl_if;
  import tpl_pkg::*;
  logic mem_clk;
  logic output_latch_enable_n;
  addr_t wr_addr;
  addr_t rd_addr_b;
  addr_t rd_addr_c;
  word_t data_in;
  word_t out_b;
  word_t out_c;
  modport dev (
    input mem_clk,
    input output_latch_enable_n,
    input wr_addr,
    input rd_addr_b,
    input rd_addr_c,
    input data_in,
    output out_b,
    output out_c
  );
  modport host (
    output mem_clk,
    output output_latch_enable_n,
    output wr_addr,
    output rd_addr_b,
    output rd_addr_c,
    output data_in,
    input out_b,
    input out_c
  );
endinterface

// *** core/tpl_memory.sv ***
// eight-word three-address latch memory, one lane per bit of the word
//
// Functional notes
// - eight three-bit words, three-address organisation
// - one write, two read address fields
// - all three fields usable at once
// - one data input, two data outputs
// - clock high presents both read words
// - clock low writes input to addressed word
// - two reads and one write per cycle
// - acts as flip-flops plus two selectors
// - clock low loads selected master latch
// - clock high loads both slave latches
// - enable low keeps slaves always transparent
// - wider words share addresses and clocks
// - deeper memory muxes outputs, demuxes clock
// - write counter drives write address, ascending
// - read counter drives first read field
// - empty memory ignores further reads
// - full memory writes and advances reader
// - first output feeds second read address
`timescale 1ns/1ns
module tpl_memory
  import tpl_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // link
  tpl_if.dev lnk
);

  // ****************************************
  // phase model
  // ****************************************
  // mem_clk high: both slaves load the masters named by the read fields
  // mem_clk low: the master named by the write field loads data_in
  // back-to-back writes keep mem_clk low, and gated slaves hold meanwhile
  // each latch is a ref_clk register that follows while open, so a phase
  // costs one edge: a word written in one cycle reaches a slave one edge
  // later and stands on the outputs from that same edge
  // enable low: slaves load on every edge whatever the clock level, which
  // lets an address counter walk the masters with no clock activity
  // limitation: a read field that moves while the slaves are closed is
  // only seen once they open again

  // ****************************************
  // storage
  // ****************************************
  // all state clears on reset, where real latch cells would come up unknown
  // eight masters, one word each
  word_t master_r [WORDS];
  word_t master_nxt [WORDS];
  // two slaves, one per read field
  word_t slave_b_r;
  word_t slave_b_nxt;
  word_t slave_c_r;
  word_t slave_c_nxt;
  // phase and address decode
  logic write_phase;
  logic slave_open;
  logic [WORDS-1:0] wr_sel;
  logic [WORDS-1:0] rd_sel_b;
  logic [WORDS-1:0] rd_sel_c;
  word_t rd_word_b;
  word_t rd_word_c;
  genvar g;
  genvar l;

  // ****************************************
  // decoders
  // ****************************************
  // one-hot word select, shared by the write field and both read fields;
  // a three-bit field always names one of the eight words
  function automatic logic [WORDS-1:0] word_hit(input addr_t a);
    word_hit = {WORDS{1'h0}};
    for (int w = 0; w < WORDS; w++) begin
      if (a == addr_t'(w)) begin
        word_hit[w] = 1'h1;
      end
    end
  endfunction

  // and-or selector of one lane; no priority, so any word may be chosen
  function automatic logic pick(input word_t mem [WORDS], input logic [WORDS-1:0] hit,
                                input int lane);
    pick = 1'h0;
    for (int w = 0; w < WORDS; w++) begin
      pick = pick | (hit[w] & mem[w][lane]);
    end
  endfunction

  // one selector per lane makes up a whole word
  function automatic word_t read_word(input word_t mem [WORDS], input logic [WORDS-1:0] hit);
    read_word = WORD_RESET;
    for (int n = 0; n < LANES; n++) begin
      read_word[n] = pick(mem, hit, n);
    end
  endfunction

  // ****************************************
  // phase decode
  // ****************************************
  // masters open only in the low phase, so address moves in the high phase
  // cannot disturb a stored word
  assign write_phase = (lnk.mem_clk == CLK_WRITE);
  assign wr_sel = write_phase ? word_hit(lnk.wr_addr) : {WORDS{1'h0}};

  // slaves open on clock high, or always when the enable is low;
  // the low enable is what a free-running reader needs
  assign slave_open = (lnk.mem_clk == CLK_IDLE) ||
                      (lnk.output_latch_enable_n == SLAVE_OPEN);

  // ****************************************
  // read select
  // ****************************************
  // read fields decode apart from the write field, so all three may name
  // the same word in one cycle; rd_addr_c may follow out_b through outside
  // logic, which settles within the cycle since out_b is a flop
  assign rd_sel_b = word_hit(lnk.rd_addr_b);
  assign rd_sel_c = word_hit(lnk.rd_addr_c);
  assign rd_word_b = read_word(master_r, rd_sel_b);
  assign rd_word_c = read_word(master_r, rd_sel_c);

  // ****************************************
  // master bank
  // ****************************************
  // one flop per word and lane; every lane shares the decode, as sliced
  // devices would share address fields and clock
  generate
    for (g = 0; g < WORDS; g++) begin : g_word
      for (l = 0; l < LANES; l++) begin : g_lane
        always_comb begin
          master_nxt[g][l] = master_r[g][l];
          if (wr_sel[g]) begin
            master_nxt[g][l] = lnk.data_in[l];
          end
        end

        always_ff @(posedge ref_clk or posedge reset) begin
          if (reset) begin
            master_r[g][l] <= WORD_RESET[l];
          end else begin
            master_r[g][l] <= master_nxt[g][l];
          end
        end
      end
    end
  endgenerate

  // ****************************************
  // slave b
  // ****************************************
  // the word taken in the high phase stands through the write phase after
  // it, unless the enable is low
  generate
    for (l = 0; l < LANES; l++) begin : g_slave_b
      always_comb begin
        slave_b_nxt[l] = slave_b_r[l];
        if (slave_open) begin
          slave_b_nxt[l] = rd_word_b[l];
        end
      end

      always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
          slave_b_r[l] <= WORD_RESET[l];
        end else begin
          slave_b_r[l] <= slave_b_nxt[l];
        end
      end
    end
  endgenerate

  // ****************************************
  // slave c
  // ****************************************
  // reads the same master snapshot as slave b, so both reads of one cycle
  // see one state of the bank
  generate
    for (l = 0; l < LANES; l++) begin : g_slave_c
      always_comb begin
        slave_c_nxt[l] = slave_c_r[l];
        if (slave_open) begin
          slave_c_nxt[l] = rd_word_c[l];
        end
      end

      always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
          slave_c_r[l] <= WORD_RESET[l];
        end else begin
          slave_c_r[l] <= slave_c_nxt[l];
        end
      end
    end
  endgenerate

  // ****************************************
  // output drive
  // ****************************************
  // straight from the slave flops; bit i of each word is lane i, and a
  // wider word only adds lanes that share every decode
  assign lnk.out_b = slave_b_r;
  assign lnk.out_c = slave_c_r;

endmodule

// *** core/tpl_ctrl.sv ***
// external controller: fifo counters, direct and indirect access
`timescale 1ns/1ns
module tpl_ctrl
  import tpl_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // link
  tpl_if.host lnk,
  // mode: 1 fifo, 0 random access
  input wire logic fifo_mode,
  // write request
  input wire logic wr_req,
  input wire addr_t wr_addr,
  input wire word_t wr_data,
  // fifo pop and random read address
  input wire logic pop,
  input wire addr_t rd_addr,
  input wire logic indirect,
  // results
  output word_t rd_data_b,
  output word_t rd_data_c,
  output logic fifo_empty,
  output logic fifo_full
);

  // ****************************************
  // state
  // ****************************************
  logic clk_r, clk_nxt;
  logic sle_n_r, sle_n_nxt;
  addr_t waddr_r, waddr_nxt;
  addr_t rb_r, rb_nxt;
  word_t din_r, din_nxt;
  addr_t wcnt_r, wcnt_nxt;
  addr_t rcnt_r, rcnt_nxt;
  logic last_wr_r, last_wr_nxt;
  word_t db_r, dc_r;
  logic empty, full;

  assign empty = (wcnt_r == rcnt_r) && !last_wr_r;
  assign full = (wcnt_r == rcnt_r) && last_wr_r;

  // ****************************************
  // next values
  // ****************************************
  always_comb begin
    clk_nxt = CLK_IDLE;
    sle_n_nxt = fifo_mode ? SLAVE_OPEN : SLAVE_GATED;
    waddr_nxt = waddr_r;
    din_nxt = din_r;
    rb_nxt = fifo_mode ? rcnt_r : rd_addr;
    wcnt_nxt = wcnt_r;
    rcnt_nxt = rcnt_r;
    last_wr_nxt = last_wr_r;
    // a write is one low clock phase; the count moves on the edge that starts it
    if (wr_req) begin
      clk_nxt = CLK_WRITE;
      din_nxt = wr_data;
      waddr_nxt = fifo_mode ? wcnt_r : wr_addr;
    end
    if (fifo_mode) begin
      if (wr_req) begin
        wcnt_nxt = wcnt_r + ADDR_STEP;
        last_wr_nxt = 1'h1;
        if (full) begin
          rcnt_nxt = rcnt_r + ADDR_STEP;
        end
      end
      if (pop && !empty && !(wr_req && full)) begin
        rcnt_nxt = rcnt_r + ADDR_STEP;
        if (!wr_req) begin
          last_wr_nxt = 1'h0;
        end
      end
      rb_nxt = rcnt_nxt;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      clk_r <= CLK_IDLE;
      sle_n_r <= SLAVE_GATED;
      waddr_r <= ADDR_RESET;
      din_r <= WORD_RESET;
      rb_r <= ADDR_RESET;
      wcnt_r <= ADDR_RESET;
      rcnt_r <= ADDR_RESET;
      last_wr_r <= 1'h0;
      db_r <= WORD_RESET;
      dc_r <= WORD_RESET;
      fifo_empty <= 1'h1;
      fifo_full <= 1'h0;
    end else begin
      clk_r <= clk_nxt;
      sle_n_r <= sle_n_nxt;
      waddr_r <= waddr_nxt;
      din_r <= din_nxt;
      rb_r <= rb_nxt;
      wcnt_r <= wcnt_nxt;
      rcnt_r <= rcnt_nxt;
      last_wr_r <= last_wr_nxt;
      db_r <= lnk.out_b;
      dc_r <= lnk.out_c;
      fifo_empty <= (wcnt_nxt == rcnt_nxt) && !last_wr_nxt;
      fifo_full <= (wcnt_nxt == rcnt_nxt) && last_wr_nxt;
    end
  end

  // ****************************************
  // link drive
  // ****************************************
  // three lanes share every address and the clock
  // one bank only, so the clock demux for depth is a plain wire
  assign lnk.mem_clk = clk_r;
  assign lnk.output_latch_enable_n = sle_n_r;
  assign lnk.wr_addr = waddr_r;
  assign lnk.rd_addr_b = rb_r;
  assign lnk.data_in = din_r;
  // indirect: word read by b is the address for c, costs no extra request
  assign lnk.rd_addr_c = indirect ? lnk.out_b : rd_addr;
  assign rd_data_b = db_r;
  assign rd_data_c = dc_r;

endmodule

// *** tb/tpl_sva.sv ***
// link assertions for the latch memory
`timescale 1ns/1ns
module tpl_sva
  import tpl_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // link
  input wire logic mem_clk,
  input wire logic output_latch_enable_n,
  input wire addr_t wr_addr,
  input wire addr_t rd_addr_b,
  input wire addr_t rd_addr_c,
  input wire word_t data_in,
  input wire word_t out_b,
  input wire word_t out_c
);
  // ****
  // reference masters
  // ****
  word_t mem_r [WORDS];
  logic op_w;
  // slaves open on clock high or forced open
  assign op_w = mem_clk | ~output_latch_enable_n;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mem_r <= '{default: WORD_RESET};
    end else if (mem_clk == CLK_WRITE) begin
      mem_r[wr_addr] <= data_in;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  property p_rd_b; $past(op_w) |-> out_b == $past(mem_r[rd_addr_b]); endproperty
  a_rd_b: assert property (p_rd_b) else $error("read b wrong");
  property p_rd_c; $past(op_w) |-> out_c == $past(mem_r[rd_addr_c]); endproperty
  a_rd_c: assert property (p_rd_c) else $error("read c wrong");
  property p_hold_b; !$past(op_w) |-> $stable(out_b); endproperty
  a_hold_b: assert property (p_hold_b) else $error("b not held");
  property p_hold_c; !$past(op_w) |-> $stable(out_c); endproperty
  a_hold_c: assert property (p_hold_c) else $error("c not held");
  property p_scan; !output_latch_enable_n |=> out_c == $past(mem_r[rd_addr_c]); endproperty
  a_scan: assert property (p_scan) else $error("scan wrong");
  property p_wr_b;
    !mem_clk ##1 (op_w && rd_addr_b == $past(wr_addr)) |=> out_b == $past(data_in, 2);
  endproperty
  a_wr_b: assert property (p_wr_b) else $error("write lost b");
  property p_wr_c;
    !mem_clk ##1 (op_w && rd_addr_c == $past(wr_addr)) |=> out_c == $past(data_in, 2);
  endproperty
  a_wr_c: assert property (p_wr_c) else $error("write lost c");
  property p_same; op_w && rd_addr_b == rd_addr_c |=> out_b == out_c; endproperty
  a_same: assert property (p_same) else $error("b c differ");
endmodule

// *** tb/three_port_latch_memory_tb.sv ***
// self-checking bench for the latch memory and its controller
`timescale 1ns/1ns
module three_port_latch_memory_tb;
  import tpl_pkg::*;
  logic ref_clk = 0, reset = 1, fifo_mode = 0, wr_req = 0, pop = 0, indirect = 0;
  addr_t wr_addr = ADDR_RESET, rd_addr = ADDR_RESET;
  word_t wr_data = WORD_RESET, rd_data_b, rd_data_c;
  logic fifo_empty, fifo_full;
  int err_total = 0, total_checks = 0;
  word_t q[$];
  tpl_if lnk();
  tpl_memory tpl_memory_i(.ref_clk(ref_clk), .reset(reset), .lnk(lnk.dev));
  tpl_ctrl tpl_ctrl_i(.ref_clk(ref_clk), .reset(reset), .lnk(lnk.host),
    .fifo_mode(fifo_mode), .wr_req(wr_req), .wr_addr(wr_addr), .wr_data(wr_data),
    .pop(pop), .rd_addr(rd_addr), .indirect(indirect), .rd_data_b(rd_data_b),
    .rd_data_c(rd_data_c), .fifo_empty(fifo_empty), .fifo_full(fifo_full));
  tpl_sva tpl_sva_i(.ref_clk(ref_clk), .reset(reset), .mem_clk(lnk.mem_clk),
    .output_latch_enable_n(lnk.output_latch_enable_n), .wr_addr(lnk.wr_addr),
    .rd_addr_b(lnk.rd_addr_b), .rd_addr_c(lnk.rd_addr_c), .data_in(lnk.data_in),
    .out_b(lnk.out_b), .out_c(lnk.out_c));
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  // ****
  // tasks
  // ****
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic chk(input word_t got, input word_t exp);
    // sample away from the edge that launches the flops
    @(negedge ref_clk);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    chk({2'h0, got}, {2'h0, exp});
  endtask
  task automatic wr(input addr_t a, input word_t d);
    @(posedge ref_clk);
    wr_req <= 1'h1;
    wr_addr <= a;
    wr_data <= d;
    @(posedge ref_clk);
    wr_req <= 1'h0;
  endtask
  // waits out the fixed address-to-result pipeline
  task automatic rd(input addr_t a, input logic ind, input word_t eb, input word_t ec);
    @(posedge ref_clk);
    rd_addr <= a;
    indirect <= ind;
    tick(6);
    chk(rd_data_b, eb);
    chk(rd_data_c, ec);
  endtask
  task automatic pulse_pop;
    @(posedge ref_clk);
    pop <= 1'h1;
    @(posedge ref_clk);
    pop <= 1'h0;
    tick(5);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    tick(20000);
    err_total++;
    $display("[ERR] %0t run limit reached", $time);
    tally_and_finish();
  end
  initial begin
    tick(8);
    reset <= 1'h0;
    for (int i = 0; i < WORDS; i++) begin
      wr(addr_t'(i), addr_t'(i) ^ 3'h5);
    end
    for (int i = 0; i < WORDS; i++) begin
      rd(addr_t'(i), 1'h0, addr_t'(i) ^ 3'h5, addr_t'(i) ^ 3'h5);
      rd(addr_t'(i), 1'h1, addr_t'(i) ^ 3'h5, addr_t'(i));
    end
    wr(3'h7, 3'h2);
    rd(3'h7, 1'h0, 3'h2, 3'h2);
    // mode changes only while idle, so under reset
    tick(1);
    reset <= 1'h1;
    fifo_mode <= 1'h1;
    tick(2);
    reset <= 1'h0;
    pulse_pop();
    chk_flag(fifo_empty, 1'h1);
    for (int i = 0; i < WORDS + 1; i++) begin
      if (q.size() == WORDS)
        void'(q.pop_front());
      q.push_back(word_t'(i + 1));
      wr(ADDR_RESET, word_t'(i + 1));
      tick(1);
      chk_flag(fifo_full, q.size() == WORDS);
    end
    tick(5);
    while (q.size() > 0) begin
      chk(rd_data_b, q.pop_front());
      pulse_pop();
    end
    chk_flag(fifo_empty, 1'h1);
    chk_flag(fifo_full, 1'h0);
    tally_and_finish();
  end
endmodule
